// ===== verif/flash_dl_asserts.sv
// port checker for the flash program download controller
`timescale 1ns/1ps
// ==========================================
// checker
module flash_dl_asserts (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // requests
  input wire logic request_wr,
  input wire logic ram_emulation_off,
  input wire logic exec_from_ram,
  input wire logic init_call,
  input wire logic prog_call,
  input wire logic [15:0] cpu_frequency_param,
  input wire logic [flash_dl_pkg::ADDR_W-1:0] program_destination_param,
  input wire logic bus_grant_other,
  // watched outputs
  input wire logic [7:0] flash_key_reg,
  input wire logic program_select_bit,
  input wire logic erase_select_bit,
  input wire logic download_request_bit,
  input wire logic [flash_dl_pkg::ADDR_W-1:0] download_destination_reg,
  input wire logic destination_error_bit,
  input wire logic download_busy,
  input wire logic irq_hold,
  input wire logic program_busy,
  input wire logic [7:0] routine_result_code,
  input wire logic routine_done,
  input wire logic error_protect,
  input wire logic [flash_dl_pkg::ADDR_W-1:0] init_entry_addr,
  input wire logic flash_we,
  input wire logic ram_we,
  input wire logic rd_from_storage
);
  import flash_dl_pkg::*;
  logic [8:0] unit_cnt;
  logic [8:0] next_unit_cnt;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // ==========================================
  // flash writes counted within one unit
  always_comb begin
    next_unit_cnt = unit_cnt + {8'h00, flash_we};
    if (!program_busy && !flash_we) next_unit_cnt = 9'h000;
  end
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) unit_cnt <= 9'h000;
    else unit_cnt <= next_unit_cnt;
  end
  // ==========================================
  // download steps
  sequence s_dl_start;
    !download_busy ##1 download_busy;
  endsequence
  sequence s_dl_end;
    download_busy ##1 !download_busy;
  endsequence
  a_request_key_gate: assert property ($rose(download_request_bit) |->
    $past(request_wr) && $past(flash_key_reg) == KEY_DOWNLOAD && $past(ram_emulation_off)
    && $past(exec_from_ram)) else $error("request bit set without its conditions");
  a_map_storage: assert property (s_dl_start |=> rd_from_storage)
    else $error("storage not mapped after download start");
  a_dl_clears: assert property (s_dl_end |-> !program_select_bit && !erase_select_bit
    && !download_request_bit && !rd_from_storage) else $error("bits not cleared at end");
  a_irq_hold_busy: assert property (irq_hold == download_busy)
    else $error("interrupt hold differs from download busy");
  a_no_flash_dl: assert property (download_busy |-> !flash_we)
    else $error("flash written during download");
  a_dest_no_write: assert property (destination_error_bit && download_busy |-> !ram_we)
    else $error("ram written with bad destination");
  a_entry_offset: assert property ($past(resetn) |->
    init_entry_addr == $past(download_destination_reg) + INIT_ENTRY_OFS)
    else $error("init entry offset wrong");
  a_prog_gate: assert property ($rose(program_busy) |-> $past(flash_key_reg) == KEY_PROGRAM
    && $past(program_destination_param) <= FLASH_HI && $past(program_destination_param[6:0]) == 7'h00)
    else $error("programming started with bad key or destination");
  a_unit_count: assert property ($fell(program_busy) && routine_result_code == RC_OK |->
    unit_cnt + {8'h00, flash_we} == UNIT_BYTES) else $error("unit byte count wrong");
  a_freq_window: assert property (init_call && !prog_call && !program_busy && !download_busy
    |=> routine_done && routine_result_code[RC_FREQ_ERR_POS] == ($past(cpu_frequency_param) < FREQ_MIN
    || $past(cpu_frequency_param) > FREQ_MAX)) else $error("frequency check wrong");
  a_bus_protect: assert property (program_busy && bus_grant_other |->
    ##[1:3] (error_protect && routine_result_code[RC_BUS_ERR_POS])) else $error("no protection");
endmodule : flash_dl_asserts

// ===== verif/flash_mem_model.sv
// memory model giving routine image and source bytes
`timescale 1ns/1ps
// ==========================================
// model
module flash_mem_model (
  // read port
  input wire logic [flash_dl_pkg::ADDR_W-1:0] rd_addr,
  input wire logic rd_from_storage,
  output logic [7:0] rd_data
);
  import flash_dl_pkg::*;
  // image byte when storage is mapped, else source byte with filler padding
  always_comb begin
    if (rd_from_storage) rd_data = rd_addr[7:0] ^ 8'h5C;
    else if (rd_addr[6:0] >= 7'h70) rd_data = 8'hFF;
    else rd_data = rd_addr[7:0] + 8'h11;
  end
endmodule : flash_mem_model

// ===== verif/flash_program_download_control_tb_top.sv
// self-checking bench for the flash program download controller
`timescale 1ns/1ps
`define CHK(act, exp) begin checked++; if ((act) !== (exp)) begin num_errors++; \
  $display("Error at %0t: got %0h expected %0h", $time, (act), (exp)); end end
// ==========================================
// bench top
module flash_program_download_control_tb_top;
  import flash_dl_pkg::*;
  logic clk_sys, resetn, key_wr, select_wr, program_select_wdata, erase_select_wdata, dest_wr;
  logic request_wr, request_wdata, ram_emulation_off, exec_from_ram, init_call, prog_call;
  logic bus_grant_other, rd_from_storage, ram_we, flash_we, program_select_bit, erase_select_bit;
  logic download_request_bit, destination_error_bit, download_busy, irq_hold, program_busy;
  logic init_done, routine_done, error_protect;
  logic [7:0] key_wdata, rd_data, wr_data, flash_key_reg, routine_result_code, last_wd;
  logic [15:0] cpu_frequency_param;
  logic [ADDR_W-1:0] dest_wdata, program_destination_param, program_source_param, rd_addr;
  logic [ADDR_W-1:0] wr_addr, download_destination_reg, init_entry_addr, prog_entry_addr;
  logic [ADDR_W-1:0] last_wa, base, src;
  int num_errors = 0;
  int checked = 0;
  int n_ram, n_flash, bad;
  flash_program_download_control flash_program_download_control_inst (.*);
  flash_mem_model flash_mem_model_inst (.*);
  function automatic logic [7:0] src_byte(input logic [23:0] a);
    return (a[6:0] >= 7'h70) ? 8'hFF : a[7:0] + 8'h11;
  endfunction : src_byte
  // ==========================================
  // write monitor
  always @(posedge clk_sys) begin
    if (ram_we) begin
      n_ram++;
      last_wa = wr_addr;
      last_wd = wr_data;
      if (wr_addr != base && wr_data !== (wr_addr[7:0] ^ 8'h5C)) bad++;
    end
    if (flash_we) begin
      n_flash++;
      if (wr_addr[23:7] !== base[23:7] || wr_data !== src_byte(src + wr_addr[6:0])) bad++;
    end
  end
  // ==========================================
  // tasks
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic wr_key(input logic [7:0] v);
    key_wr = 1'b1;
    key_wdata = v;
    tick(1);
    key_wr = 1'b0;
    tick(1);
  endtask : wr_key
  task automatic t_refuse;
    for (int i = 0; i < 3; i++) begin
      wr_key(i == 0 ? KEY_RESET : KEY_DOWNLOAD);
      ram_emulation_off = (i != 1);
      exec_from_ram = (i != 2);
      n_ram = 0;
      request_wr = 1'b1;
      tick(1);
      request_wr = 1'b0;
      `CHK(download_request_bit, 1'b0)
      tick(3);
      `CHK(download_busy, 1'b0)
      `CHK(n_ram, 0)
    end
    ram_emulation_off = 1'b1;
    exec_from_ram = 1'b1;
    $display("test refuse done");
  endtask : t_refuse
  task automatic t_dl(input logic [23:0] d, input logic ps, es, kill, input int n,
                      input logic [7:0] r, input logic de);
    int w;
    wr_key(KEY_DOWNLOAD);
    dest_wr = 1'b1;
    dest_wdata = d;
    select_wr = 1'b1;
    program_select_wdata = ps;
    erase_select_wdata = es;
    tick(1);
    dest_wr = 1'b0;
    select_wr = 1'b0;
    base = d;
    n_ram = 0;
    bad = 0;
    last_wd = 8'hFF;
    request_wr = 1'b1;
    tick(1);
    request_wr = 1'b0;
    `CHK(download_request_bit, 1'b1)
    if (kill) wr_key(KEY_RESET);
    else tick(2);
    w = 0;
    while (download_busy && w < 400) begin
      tick(1);
      w++;
    end
    `CHK(w < 400, 1'b1)
    `CHK(n_ram, n)
    if (n > 0) `CHK(last_wa, d)
    `CHK(last_wd, (n > 0) ? r : 8'hFF)
    `CHK(destination_error_bit, de)
    `CHK({program_select_bit, erase_select_bit, download_request_bit}, 3'b000)
    `CHK(bad, 0)
    `CHK(init_entry_addr, d + INIT_ENTRY_OFS)
    `CHK(prog_entry_addr, d + PROG_ENTRY_OFS)
    wr_key(KEY_RESET);
    $display("test download %0h done", d);
  endtask : t_dl
  task automatic t_init(input logic [15:0] f, input logic e);
    init_call = 1'b1;
    cpu_frequency_param = f;
    tick(1);
    init_call = 1'b0;
    `CHK(routine_done, 1'b1)
    `CHK(routine_result_code[RC_FREQ_ERR_POS], e)
    if (!e) `CHK(init_done, 1'b1)
    tick(1);
    $display("test init %0h done", f);
  endtask : t_init
  task automatic t_prog(input logic [23:0] d, s, input logic [7:0] k, input int n,
                        input logic [7:0] c, input logic brk);
    int w;
    wr_key(k);
    base = d;
    src = s;
    n_flash = 0;
    bad = 0;
    program_destination_param = d;
    program_source_param = s;
    prog_call = 1'b1;
    tick(1);
    prog_call = 1'b0;
    if (brk) tick(20);
    bus_grant_other = brk;
    w = 0;
    while (!routine_done && w < 300) begin
      tick(1);
      w++;
    end
    `CHK(w < 300, 1'b1)
    if (brk) `CHK({error_protect, routine_result_code[RC_BUS_ERR_POS]}, 2'b11)
    if (!brk) `CHK(routine_result_code, c)
    if (!brk) `CHK(n_flash, n)
    `CHK(bad, 0)
    tick(1);
    bus_grant_other = 1'b0;
    $display("test program %0h done", d);
  endtask : t_prog
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  // ==========================================
  // clock, watchdog, main sequence
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // about 700 cycles expected, limit 20000
  initial begin
    #400000;
    num_errors++;
    tally_and_finish();
  end
  initial begin
    {key_wr, select_wr, program_select_wdata, erase_select_wdata, dest_wr, request_wr} = '0;
    {init_call, prog_call, bus_grant_other, key_wdata, dest_wdata, cpu_frequency_param} = '0;
    {program_destination_param, program_source_param, base, src} = '0;
    {request_wdata, ram_emulation_off, exec_from_ram} = 3'b111;
    resetn = 1'b0;
    tick(20);
    resetn = 1'b1;
    tick(1);
    t_refuse();
    t_dl(24'hFF9000, 1'b1, 1'b0, 1'b0, 256, 8'h00, 1'b0);
    t_dl(24'hFF9800, 1'b1, 1'b1, 1'b0, 1, 8'h40, 1'b0);
    t_dl(24'hFF9800, 1'b0, 1'b0, 1'b0, 1, 8'h40, 1'b0);
    t_dl(24'hFF9000, 1'b1, 1'b0, 1'b1, 1, 8'h80, 1'b0);
    t_dl(24'h000100, 1'b1, 1'b0, 1'b0, 0, 8'h00, 1'b1);
    t_init(16'h031F, 1'b1);
    t_init(16'h0320, 1'b0);
    t_init(16'h1388, 1'b0);
    t_init(16'h1389, 1'b1);
    t_prog(24'h000080, 24'hFF8000, KEY_PROGRAM, 128, 8'h00, 1'b0);
    t_prog(24'h000100, 24'hFF8080, KEY_PROGRAM, 128, 8'h00, 1'b0);
    t_prog(24'h000240, 24'hFF8000, KEY_PROGRAM, 0, 8'h02, 1'b0);
    t_prog(24'h080000, 24'hFF8000, KEY_PROGRAM, 0, 8'h02, 1'b0);
    t_prog(24'h000200, 24'h001000, KEY_PROGRAM, 0, 8'h04, 1'b0);
    t_prog(24'h000200, 24'hFF8000, KEY_DOWNLOAD, 0, 8'h08, 1'b0);
    t_prog(24'h000300, 24'hFF8000, KEY_PROGRAM, 0, 8'h10, 1'b1);
    t_prog(24'h000400, 24'hFF8000, KEY_PROGRAM, 0, 8'h10, 1'b0);
    tally_and_finish();
  end
endmodule : flash_program_download_control_tb_top
bind flash_program_download_control flash_dl_asserts flash_dl_asserts_inst (.*);

// ===== verilog/flash_dl_pkg.sv
// constants and types for the flash program download controller
package flash_dl_pkg;

  // ==========================================================================
  // widths
  localparam int ADDR_W = 24;
  localparam int CNT_W = 9;

  // ==========================================================================
  // key values
  localparam logic [7:0] KEY_DOWNLOAD = 8'hA5;
  localparam logic [7:0] KEY_PROGRAM = 8'h5A;
  localparam logic [7:0] KEY_RESET = 8'h00;

  // ==========================================================================
  // programming unit
  localparam logic [CNT_W-1:0] UNIT_BYTES = 9'h080;
  localparam logic [7:0] UNIT_ALIGN_LO = 8'h00;
  localparam logic [7:0] UNIT_ALIGN_HI = 8'h80;

  // ==========================================================================
  // downloaded image
  localparam logic [CNT_W-1:0] IMAGE_BYTES = 9'h100;
  localparam logic [ADDR_W-1:0] INIT_ENTRY_OFS = 24'h000020;
  localparam logic [ADDR_W-1:0] PROG_ENTRY_OFS = 24'h000010;

  // ==========================================================================
  // address map
  localparam logic [ADDR_W-1:0] FLASH_LO = 24'h000000;
  localparam logic [ADDR_W-1:0] FLASH_HI = 24'h07FFFF;
  localparam logic [ADDR_W-1:0] DL_DEST_LO = 24'hFF9000;
  localparam logic [ADDR_W-1:0] DL_DEST_HI = 24'hFFBEFF;

  // ==========================================================================
  // cpu frequency window, units of 10 kHz
  localparam logic [15:0] FREQ_MIN = 16'h0320;
  localparam logic [15:0] FREQ_MAX = 16'h1388;

  // ==========================================================================
  // download result byte
  localparam logic [7:0] DL_RESULT_OK = 8'h00;
  localparam int DL_SEL_ERR_POS = 6;
  localparam int DL_KEY_ERR_POS = 7;

  // ==========================================================================
  // routine result code
  localparam logic [7:0] RC_OK = 8'h00;
  localparam int RC_FREQ_ERR_POS = 0;
  localparam int RC_DEST_ERR_POS = 1;
  localparam int RC_SRC_ERR_POS = 2;
  localparam int RC_KEY_ERR_POS = 3;
  localparam int RC_BUS_ERR_POS = 4;

  // ==========================================================================
  // reset values
  localparam logic [7:0] RESULT_RESET = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 24'h000000;

  // ==========================================================================
  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_MAP,
    ST_CHECK,
    ST_COPY,
    ST_RESULT,
    ST_UNMAP,
    ST_PROG
  } seq_state_e;

endpackage : flash_dl_pkg

// ===== verilog/flash_program_download_control.sv
// flash program download controller and routine parameter checker
//
// Overview of operation
// (RULE1) each programming run writes exactly one 128-byte unit
// (RULE2) software pads a short unit with H'FF filler bytes
// (RULE3) program select picks the routine; multiple selection reports a selection error
// (RULE4) download request is refused unless the key register holds H'A5
// (RULE5) request also needs RAM emulation off and execution from on-chip RAM
// (RULE6) software zeroes the vector base before requesting, may restore it later
// (RULE7) on request, map routine storage, check selection and destination, copy to RAM
// (RULE8) after download clear both selects and request, write result byte at destination
// (RULE9) interrupts are held, not taken, while a download runs
// (RULE10) software performs two dummy status reads right after requesting
// (RULE11) software presets the result byte to H'FF before requesting
// (RULE12) no other bus master may access flash during a download
// (RULE13) software clears the key register to H'00 after download
// (RULE14) result H'00 is success; unchanged means bad destination; else error bits
// (RULE15) initialization accepts only 8 to 50 MHz, otherwise error and no init
// (RULE16) init entry is destination plus 32, programming entry plus 16
// (RULE17) bus mastership leaving the CPU during programming enters error protection
// (RULE18) software masks interrupts and avoids NMI while programming
// (RULE19) software writes H'5A to the key register before programming
// (RULE20) destination outside flash or not 128-byte aligned is rejected, nothing written
// (RULE21) source data located in flash is rejected without programming
// (RULE22) software never reprograms an already programmed unit
// (RULE23) a request lacking any condition is ignored, bit stays 0, no transfer
`timescale 1ns/1ps

module flash_program_download_control (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // key register write
  input wire logic key_wr,
  input wire logic [7:0] key_wdata,
  // select register writes
  input wire logic select_wr,
  input wire logic program_select_wdata,
  input wire logic erase_select_wdata,
  // destination register write
  input wire logic dest_wr,
  input wire logic [flash_dl_pkg::ADDR_W-1:0] dest_wdata,
  // download request write and its conditions
  input wire logic request_wr,
  input wire logic request_wdata,
  input wire logic ram_emulation_off,
  input wire logic exec_from_ram,
  // routine calls
  input wire logic init_call,
  input wire logic [15:0] cpu_frequency_param,
  input wire logic prog_call,
  input wire logic [flash_dl_pkg::ADDR_W-1:0] program_destination_param,
  input wire logic [flash_dl_pkg::ADDR_W-1:0] program_source_param,
  input wire logic bus_grant_other,
  // memory read port
  input wire logic [7:0] rd_data,
  output logic [flash_dl_pkg::ADDR_W-1:0] rd_addr,
  output logic rd_from_storage,
  // memory write port
  output logic [flash_dl_pkg::ADDR_W-1:0] wr_addr,
  output logic [7:0] wr_data,
  output logic ram_we,
  output logic flash_we,
  // register views
  output logic [7:0] flash_key_reg,
  output logic program_select_bit,
  output logic erase_select_bit,
  output logic download_request_bit,
  output logic [flash_dl_pkg::ADDR_W-1:0] download_destination_reg,
  output logic destination_error_bit,
  // status
  output logic download_busy,
  output logic irq_hold,
  output logic program_busy,
  output logic init_done,
  output logic [7:0] routine_result_code,
  output logic routine_done,
  output logic error_protect,
  output logic [flash_dl_pkg::ADDR_W-1:0] init_entry_addr,
  output logic [flash_dl_pkg::ADDR_W-1:0] prog_entry_addr
);
  import flash_dl_pkg::*;

  // ==========================================================================
  // helpers
  function automatic logic in_range(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] lo,
                                    input logic [ADDR_W-1:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  function automatic logic [ADDR_W-1:0] add_ofs(input logic [ADDR_W-1:0] base,
                                                input logic [CNT_W-1:0] ofs);
    add_ofs = base + {{(ADDR_W-CNT_W){1'b0}}, ofs};
  endfunction : add_ofs

  // ==========================================================================
  // state
  seq_state_e state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic [CNT_W-1:0] pend_idx, next_pend_idx;
  logic pend, next_pend;
  logic [ADDR_W-1:0] prog_dst, next_prog_dst;
  logic [ADDR_W-1:0] prog_src, next_prog_src;
  logic [7:0] dl_result, next_dl_result;
  logic [7:0] next_flash_key_reg;
  logic next_program_select_bit, next_erase_select_bit, next_download_request_bit;
  logic [ADDR_W-1:0] next_download_destination_reg;
  logic next_destination_error_bit;
  logic [ADDR_W-1:0] next_rd_addr, next_wr_addr;
  logic [7:0] next_wr_data;
  logic next_ram_we, next_flash_we, next_rd_from_storage;
  logic next_download_busy, next_irq_hold, next_program_busy, next_init_done;
  logic [7:0] next_routine_result_code;
  logic next_routine_done, next_error_protect;
  logic [ADDR_W-1:0] next_init_entry_addr, next_prog_entry_addr;
  logic request_ok;
  logic sel_bad;
  logic [7:0] rc;

  // ==========================================================================
  // next-state logic
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_pend_idx = pend_idx;
    next_pend = 1'b0;
    next_prog_dst = prog_dst;
    next_prog_src = prog_src;
    next_dl_result = dl_result;
    next_flash_key_reg = flash_key_reg;
    next_program_select_bit = program_select_bit;
    next_erase_select_bit = erase_select_bit;
    next_download_request_bit = download_request_bit;
    next_download_destination_reg = download_destination_reg;
    next_destination_error_bit = destination_error_bit;
    next_rd_addr = rd_addr;
    next_rd_from_storage = rd_from_storage;
    next_wr_addr = wr_addr;
    next_wr_data = wr_data;
    next_ram_we = 1'b0;
    next_flash_we = 1'b0;
    next_init_done = init_done;
    next_routine_result_code = routine_result_code;
    next_routine_done = 1'b0;
    next_error_protect = error_protect;
    next_init_entry_addr = add_ofs(download_destination_reg, INIT_ENTRY_OFS[CNT_W-1:0]); // see (RULE16)
    next_prog_entry_addr = add_ofs(download_destination_reg, PROG_ENTRY_OFS[CNT_W-1:0]); // see (RULE16)
    request_ok = (flash_key_reg == KEY_DOWNLOAD) // see (RULE4)
                 && ram_emulation_off && exec_from_ram; // see (RULE5)
    sel_bad = !(program_select_bit ^ erase_select_bit); // see (RULE3)
    rc = RC_OK;

    if (key_wr) begin
      next_flash_key_reg = key_wdata;
    end
    if (state == ST_IDLE) begin
      if (select_wr) begin
        next_program_select_bit = program_select_wdata; // see (RULE3)
        next_erase_select_bit = erase_select_wdata;
      end
      if (dest_wr) begin
        next_download_destination_reg = dest_wdata;
      end
    end

    case (state)
      ST_IDLE: begin
        if (request_wr && request_wdata && request_ok) begin
          next_download_request_bit = 1'b1;
          next_state = ST_MAP; // see (RULE7)
        end else if (prog_call) begin
          if (flash_key_reg != KEY_PROGRAM) begin
            rc[RC_KEY_ERR_POS] = 1'b1;
          end
          if (!in_range(program_destination_param, FLASH_LO, FLASH_HI)
              || ((program_destination_param[7:0] != UNIT_ALIGN_LO)
                  && (program_destination_param[7:0] != UNIT_ALIGN_HI))) begin
            rc[RC_DEST_ERR_POS] = 1'b1; // see (RULE20)
          end
          if (in_range(program_source_param, FLASH_LO, FLASH_HI)) begin
            rc[RC_SRC_ERR_POS] = 1'b1; // see (RULE21)
          end
          if (error_protect) begin
            rc[RC_BUS_ERR_POS] = 1'b1;
          end
          if (rc == RC_OK) begin
            next_prog_dst = program_destination_param;
            next_prog_src = program_source_param;
            next_cnt = '0;
            next_state = ST_PROG;
          end else begin
            next_routine_result_code = rc; // see (RULE20) (RULE21)
            next_routine_done = 1'b1;
          end
        end else if (init_call) begin
          if ((cpu_frequency_param < FREQ_MIN) || (cpu_frequency_param > FREQ_MAX)) begin
            rc[RC_FREQ_ERR_POS] = 1'b1; // see (RULE15)
          end else begin
            next_init_done = 1'b1;
          end
          next_routine_result_code = rc;
          next_routine_done = 1'b1;
        end
      end
      ST_MAP: begin
        next_rd_from_storage = 1'b1; // see (RULE7)
        next_state = ST_CHECK;
      end
      ST_CHECK: begin
        next_dl_result = DL_RESULT_OK;
        next_dl_result[DL_SEL_ERR_POS] = sel_bad; // see (RULE3)
        next_dl_result[DL_KEY_ERR_POS] = (flash_key_reg != KEY_DOWNLOAD);
        if (!in_range(download_destination_reg, DL_DEST_LO, DL_DEST_HI)) begin
          next_destination_error_bit = 1'b1; // see (RULE14)
          next_state = ST_UNMAP;
        end else if (sel_bad || (flash_key_reg != KEY_DOWNLOAD)) begin
          next_destination_error_bit = 1'b0;
          next_state = ST_RESULT;
        end else begin
          next_destination_error_bit = 1'b0;
          next_cnt = 9'h001;
          next_state = ST_COPY;
        end
      end
      ST_COPY: begin
        if (cnt < IMAGE_BYTES) begin
          next_rd_addr = {{(ADDR_W-CNT_W){1'b0}}, cnt};
          next_pend = 1'b1;
          next_pend_idx = cnt;
          next_cnt = cnt + 9'h001;
        end else if (!pend) begin
          next_state = ST_RESULT;
        end
        if (pend) begin
          next_wr_addr = add_ofs(download_destination_reg, pend_idx); // see (RULE7)
          next_wr_data = rd_data;
          next_ram_we = 1'b1;
        end
      end
      ST_RESULT: begin
        next_wr_addr = download_destination_reg;
        next_wr_data = dl_result; // see (RULE8) (RULE14)
        next_ram_we = 1'b1;
        next_state = ST_UNMAP;
      end
      ST_UNMAP: begin
        next_rd_from_storage = 1'b0;
        next_program_select_bit = 1'b0; // see (RULE8)
        next_erase_select_bit = 1'b0;
        next_download_request_bit = 1'b0;
        next_state = ST_IDLE;
      end
      ST_PROG: begin
        if (bus_grant_other) begin
          next_error_protect = 1'b1; // see (RULE17)
          rc[RC_BUS_ERR_POS] = 1'b1;
          next_routine_result_code = rc;
          next_routine_done = 1'b1;
          next_state = ST_IDLE;
        end else begin
          if (cnt < UNIT_BYTES) begin
            next_rd_addr = add_ofs(prog_src, cnt); // see (RULE1)
            next_pend = 1'b1;
            next_pend_idx = cnt;
            next_cnt = cnt + 9'h001;
          end else if (!pend) begin
            next_routine_result_code = RC_OK;
            next_routine_done = 1'b1;
            next_state = ST_IDLE;
          end
          if (pend) begin
            next_wr_addr = add_ofs(prog_dst, pend_idx); // see (RULE1)
            next_wr_data = rd_data;
            next_flash_we = 1'b1;
          end
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase

    next_download_busy = (next_state != ST_IDLE) && (next_state != ST_PROG);
    next_irq_hold = next_download_busy; // see (RULE9)
    next_program_busy = (next_state == ST_PROG);
  end

  // ==========================================================================
  // registers
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
      cnt <= '0;
      pend_idx <= '0;
      pend <= 1'b0;
      prog_dst <= ADDR_RESET;
      prog_src <= ADDR_RESET;
      dl_result <= RESULT_RESET;
      flash_key_reg <= KEY_RESET;
      program_select_bit <= 1'b0;
      erase_select_bit <= 1'b0;
      download_request_bit <= 1'b0; // see (RULE23)
      download_destination_reg <= ADDR_RESET;
      destination_error_bit <= 1'b0;
      rd_addr <= ADDR_RESET;
      rd_from_storage <= 1'b0;
      wr_addr <= ADDR_RESET;
      wr_data <= RESULT_RESET;
      ram_we <= 1'b0;
      flash_we <= 1'b0;
      download_busy <= 1'b0;
      irq_hold <= 1'b0;
      program_busy <= 1'b0;
      init_done <= 1'b0;
      routine_result_code <= RESULT_RESET;
      routine_done <= 1'b0;
      error_protect <= 1'b0;
      init_entry_addr <= ADDR_RESET;
      prog_entry_addr <= ADDR_RESET;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      pend_idx <= next_pend_idx;
      pend <= next_pend;
      prog_dst <= next_prog_dst;
      prog_src <= next_prog_src;
      dl_result <= next_dl_result;
      flash_key_reg <= next_flash_key_reg;
      program_select_bit <= next_program_select_bit;
      erase_select_bit <= next_erase_select_bit;
      download_request_bit <= next_download_request_bit;
      download_destination_reg <= next_download_destination_reg;
      destination_error_bit <= next_destination_error_bit;
      rd_addr <= next_rd_addr;
      rd_from_storage <= next_rd_from_storage;
      wr_addr <= next_wr_addr;
      wr_data <= next_wr_data;
      ram_we <= next_ram_we;
      flash_we <= next_flash_we;
      download_busy <= next_download_busy;
      irq_hold <= next_irq_hold;
      program_busy <= next_program_busy;
      init_done <= next_init_done;
      routine_result_code <= next_routine_result_code;
      routine_done <= next_routine_done;
      error_protect <= next_error_protect;
      init_entry_addr <= next_init_entry_addr;
      prog_entry_addr <= next_prog_entry_addr;
    end
  end

endmodule : flash_program_download_control
